// file: hw/slave_port_defines.vh
// register offsets, field positions, reset values and timing for the slave byte port
`ifndef SLAVE_PORT_DEFINES_VH
`define SLAVE_PORT_DEFINES_VH

`define ADDR_W            8
`define OFF_DATA_LATCH    8'h08
`define OFF_CTRL_PINS     8'h09
`define OFF_IRQ_FLAGS     8'h0C
`define OFF_STATUS_DIR    8'h89
`define OFF_IRQ_ENABLES   8'h8C
`define OFF_ANALOG_CFG    8'h9F
`define OFF_IRQ_CLEAR     8'hA0

`define BIT_IBF           7
`define BIT_OBF           6
`define BIT_INPUT_OVERFLOW_FLAG          5
`define BIT_MODE          4
`define BIT_PORT_IRQ      7
`define DIR_RESET         3'h7
`define ANALOG_RESET      5'h00
`define ANALOG_ALL_DIG    4'h6
`define ADFM_BIT          7

// four-phase instruction clock: phase count 0..3, phase two = 1, phase four = 3
`define PHASE_TWO         2'h1
`define PHASE_FOUR        2'h3

`endif

// file: hw/slave_byte_port.v
// slave byte port: external asynchronous 8-bit port with firmware register access
//
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
module slave_byte_port
#(
  parameter DATA_W = 8
)
(
  // clock and reset
  input  wire              clk,
  input  wire              sys_rst,
  // firmware register port
  input  wire [7:0]        reg_addr,
  input  wire [7:0]        reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [7:0]        reg_rdata,
  // external master pins
  input  wire [DATA_W-1:0] data_in,
  output reg  [DATA_W-1:0] data_out,
  output reg  [DATA_W-1:0] data_oe,
  input  wire              read_strobe_pin_n,
  input  wire              write_strobe_pin_n,
  input  wire              chip_select_pin_n,
  // interrupt
  output reg               irq
);

`include "slave_port_defines.vh"

  // -------------------------------------------------------
  // registers
  // -------------------------------------------------------
  reg [DATA_W-1:0] out_latch_r;
  reg [DATA_W-1:0] in_latch_r;
  reg              input_full_flag_r;
  reg              output_full_flag_r;
  reg              input_overflow_flag_r;
  reg              slave_mode_select_r;
  reg [2:0]        ctrl_dir_r;
  reg [2:0]        ctrl_out_r;
  reg [4:0]        analog_cfg_r;
  reg              port_irq_flag_r;
  reg              port_irq_enable_r;
  reg [1:0]        phase_r;

  // -------------------------------------------------------
  // pin synchronisers: three stages for the strobes, two for the data, stage one feeds stage two only
  // -------------------------------------------------------
  reg [2:0]        rd_s_r;
  reg [2:0]        wr_s_r;
  reg [2:0]        cs_s_r;
  reg [DATA_W-1:0] din_s1_r;
  reg [DATA_W-1:0] din_s2_r;
  reg              rd_n_r;
  reg              wr_n_r;
  reg              cs_n_r;

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      rd_s_r <= 3'h7;
      wr_s_r <= 3'h7;
      cs_s_r <= 3'h7;
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      cs_n_r <= 1'b1;
      din_s1_r <= {DATA_W{1'b0}};
      din_s2_r <= {DATA_W{1'b0}};
    end
    else
    begin
      rd_s_r <= {rd_s_r[1:0], read_strobe_pin_n};
      wr_s_r <= {wr_s_r[1:0], write_strobe_pin_n};
      cs_s_r <= {cs_s_r[1:0], chip_select_pin_n};
      din_s1_r <= data_in;
      din_s2_r <= din_s1_r;
      // a level counts only once stages two and three agree
      if (rd_s_r[1] == rd_s_r[2])
        rd_n_r <= rd_s_r[2];
      if (wr_s_r[1] == wr_s_r[2])
        wr_n_r <= wr_s_r[2];
      if (cs_s_r[1] == cs_s_r[2])
        cs_n_r <= cs_s_r[2];
    end
  end

  // -------------------------------------------------------
  // cycle detection
  // -------------------------------------------------------
  wire wr_act  = slave_mode_select_r & ~cs_n_r & ~wr_n_r;
  wire rd_act  = slave_mode_select_r & ~cs_n_r & ~rd_n_r;
  reg  wr_act_d_r;
  reg  rd_act_d_r;
  wire rd_start = rd_act & ~rd_act_d_r;
  // data pins pass only two flops, so sample them against stage two of the
  // strobes; gating on the slower confirmed level would latch the bus after release
  wire wr_cap   = slave_mode_select_r & ~cs_s_r[1] & ~wr_s_r[1];
  // full flags drop in the same cycle as the mode bit, never one cycle late
  wire mode_off = ~slave_mode_select_r | (wr_status & ~reg_wdata[`BIT_MODE]);
  // level-sensed end: active state dropped
  wire wr_end   = wr_act_d_r & ~wr_act;
  wire rd_end   = rd_act_d_r & ~rd_act;

  // completion waits for phase two, then lands on phase four
  reg  wr_pend_r;
  reg  rd_pend_r;
  reg  wr_seen2_r;
  reg  rd_seen2_r;
  wire wr_done = wr_pend_r & wr_seen2_r & (phase_r == `PHASE_FOUR);
  wire rd_done = rd_pend_r & rd_seen2_r & (phase_r == `PHASE_FOUR);

  // -------------------------------------------------------
  // register decode
  // -------------------------------------------------------
  wire wr_data   = reg_wr & (reg_addr == `OFF_DATA_LATCH);
  wire rd_data   = reg_rd & (reg_addr == `OFF_DATA_LATCH);
  wire wr_status = reg_wr & (reg_addr == `OFF_STATUS_DIR);
  wire wr_flags  = reg_wr & (reg_addr == `OFF_IRQ_FLAGS);
  wire wr_clear  = reg_wr & (reg_addr == `OFF_IRQ_CLEAR);

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      phase_r <= 2'h0;
      wr_act_d_r <= 1'b0;
      rd_act_d_r <= 1'b0;
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      wr_seen2_r <= 1'b0;
      rd_seen2_r <= 1'b0;
      out_latch_r <= {DATA_W{1'b0}};
      in_latch_r <= {DATA_W{1'b0}};
      input_full_flag_r <= 1'b0;
      output_full_flag_r <= 1'b0;
      input_overflow_flag_r <= 1'b0;
      slave_mode_select_r <= 1'b0;
      ctrl_dir_r <= `DIR_RESET;
      ctrl_out_r <= 3'h0;
      analog_cfg_r <= `ANALOG_RESET;
      port_irq_flag_r <= 1'b0;
      port_irq_enable_r <= 1'b0;
    end
    else
    begin
      phase_r <= phase_r + 2'h1;
      wr_act_d_r <= wr_act;
      rd_act_d_r <= rd_act;
      // capture pin data while the write is active
      if (wr_cap)
        in_latch_r <= din_s2_r;
      // write and read completion tracking
      if (wr_end)
      begin
        wr_pend_r <= 1'b1;
        wr_seen2_r <= 1'b0;
      end
      else if (wr_done)
        wr_pend_r <= 1'b0;
      else if (wr_pend_r && phase_r == `PHASE_TWO)
        wr_seen2_r <= 1'b1;
      if (rd_end)
      begin
        rd_pend_r <= 1'b1;
        rd_seen2_r <= 1'b0;
      end
      else if (rd_done)
        rd_pend_r <= 1'b0;
      else if (rd_pend_r && phase_r == `PHASE_TWO)
        rd_seen2_r <= 1'b1;
      // firmware writes
      if (wr_data)
        out_latch_r <= reg_wdata[DATA_W-1:0];
      if (reg_wr && reg_addr == `OFF_CTRL_PINS)
        ctrl_out_r <= reg_wdata[2:0];
      if (wr_status)
      begin
        slave_mode_select_r <= reg_wdata[`BIT_MODE];
        ctrl_dir_r <= reg_wdata[2:0];
      end
      if (reg_wr && reg_addr == `OFF_ANALOG_CFG)
        analog_cfg_r <= {reg_wdata[`ADFM_BIT], reg_wdata[3:0]};
      if (reg_wr && reg_addr == `OFF_IRQ_ENABLES)
        port_irq_enable_r <= reg_wdata[`BIT_PORT_IRQ];
      // input full: set wins over the firmware read
      if (mode_off)
        input_full_flag_r <= 1'b0;
      else if (wr_done)
        input_full_flag_r <= 1'b1;
      else if (rd_data)
        input_full_flag_r <= 1'b0;
      // output full
      if (mode_off)
        output_full_flag_r <= 1'b0;
      else if (rd_start)
        output_full_flag_r <= 1'b0;
      else if (wr_data)
        output_full_flag_r <= 1'b1;
      // overflow: kept across mode off, firmware clears via status write
      if (wr_done && input_full_flag_r && !rd_data)
        input_overflow_flag_r <= 1'b1;
      else if (wr_status && !reg_wdata[`BIT_INPUT_OVERFLOW_FLAG])
        input_overflow_flag_r <= 1'b0;
      // port irq flag: hardware set wins over firmware clear
      if (wr_done || rd_done)
        port_irq_flag_r <= 1'b1;
      else if (wr_flags && !reg_wdata[`BIT_PORT_IRQ])
        port_irq_flag_r <= 1'b0;
      else if (wr_clear && reg_wdata[`BIT_PORT_IRQ])
        port_irq_flag_r <= 1'b0;
    end
  end

  // -------------------------------------------------------
  // read data and pin outputs
  // -------------------------------------------------------
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      reg_rdata <= 8'h00;
      data_out <= {DATA_W{1'b0}};
      data_oe <= {DATA_W{1'b0}};
      irq <= 1'b0;
    end
    else
    begin
      reg_rdata <= 8'h00;
      if (reg_rd)
      begin
        case (reg_addr)
          `OFF_DATA_LATCH:  reg_rdata <= in_latch_r;
          `OFF_CTRL_PINS:   reg_rdata <= {5'h00, ctrl_out_r};
          `OFF_IRQ_FLAGS:   reg_rdata <= {port_irq_flag_r, 7'h00};
          `OFF_STATUS_DIR:  reg_rdata <= {input_full_flag_r, output_full_flag_r,
                                          input_overflow_flag_r, slave_mode_select_r,
                                          1'b0, ctrl_dir_r};
          `OFF_IRQ_ENABLES: reg_rdata <= {port_irq_enable_r, 7'h00};
          `OFF_ANALOG_CFG:  reg_rdata <= {analog_cfg_r[4], 3'h0, analog_cfg_r[3:0]};
          default:          reg_rdata <= 8'h00;
        endcase
      end
      // the synchroniser delays the drive a few cycles after the strobes fall
      data_out <= out_latch_r;
      data_oe <= {DATA_W{rd_act}};
      irq <= port_irq_flag_r & port_irq_enable_r;
    end
  end

endmodule

// file: verif/ext_master_model.sv
// external microprocessor model driving the slave byte port pins
`timescale 1ns/10ps
module ext_master_model
(
  // clock
  input  wire       clk,
  // port pins
  output reg        cs_n = 1'b1,
  output reg        rd_n = 1'b1,
  output reg        wr_n = 1'b1,
  output reg  [7:0] dq   = 8'h00,
  input  wire [7:0] pin_out,
  input  wire [7:0] pin_oe
);
  // released bus shows the inverse byte so a stale value never passes for data
  task mwrite(input [7:0] v);
  begin
    dq <= v;
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    repeat (8) @(posedge clk);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    @(posedge clk);
    dq <= ~v;
    repeat (15) @(posedge clk);
  end
  endtask
  task mread(output [7:0] v);
  begin
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    repeat (8) @(posedge clk);
    v = (pin_oe === 8'hFF) ? pin_out : ~pin_out;
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (16) @(posedge clk);
  end
  endtask
endmodule

// file: verif/slave_byte_port_properties.sv
// concurrent checks on the slave byte port pins and register read port
`timescale 1ns/10ps
module slave_byte_port_properties
#(
  parameter DATA_W = 8
)
(
  input wire              clk,
  input wire              sys_rst,
  input wire [7:0]        reg_addr,
  input wire [7:0]        reg_wdata,
  input wire              reg_wr,
  input wire              reg_rd,
  input wire [7:0]        reg_rdata,
  input wire [DATA_W-1:0] data_in,
  input wire [DATA_W-1:0] data_out,
  input wire [DATA_W-1:0] data_oe,
  input wire              read_strobe_pin_n,
  input wire              write_strobe_pin_n,
  input wire              chip_select_pin_n,
  input wire              irq
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence no_read;
    (chip_select_pin_n || read_strobe_pin_n) [*8];
  endsequence
  sequence ctrl_wr_rd;
    reg_wr && reg_addr == 8'h09 ##1 reg_rd && reg_addr == 8'h09;
  endsequence
  a_oe_released: assert property (no_read |-> data_oe == 0)
    else $error("data pins driven outside a read");
  a_oe_whole: assert property (data_oe != 0 |-> data_oe == {DATA_W{1'b1}})
    else $error("partial data drive");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h55 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_resv_zero: assert property (reg_rd && reg_addr == 8'h89 |=> !reg_rdata[3])
    else $error("unused status bit set");
  a_data_hold: assert property ($changed(data_out) |-> $past(reg_wr && reg_addr == 8'h08) ||
    $past(reg_wr && reg_addr == 8'h08, 2))
    else $error("output latch changed without write");
  a_irq_masked: assert property (reg_wr && reg_addr == 8'h8C && !reg_wdata[7] |-> ##2 !irq)
    else $error("irq not masked");
  a_ctrl_store: assert property (ctrl_wr_rd |=> reg_rdata[2:0] == $past(reg_wdata[2:0], 2))
    else $error("control bits not stored");
endmodule
bind slave_byte_port slave_byte_port_properties #(.DATA_W(DATA_W)) slave_byte_port_properties_i (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .data_in(data_in), .data_out(data_out),
  .data_oe(data_oe), .read_strobe_pin_n(read_strobe_pin_n),
  .write_strobe_pin_n(write_strobe_pin_n), .chip_select_pin_n(chip_select_pin_n), .irq(irq));

// file: verif/slave_byte_port_tb.sv
// self-checking bench for the slave byte port
`timescale 1ns/10ps
module slave_byte_port_tb;
  reg         clk       = 1'b0;
  reg         sys_rst   = 1'b1;
  reg  [7:0]  reg_addr  = 8'h00;
  reg  [7:0]  reg_wdata = 8'h00;
  reg         reg_wr    = 1'b0;
  reg         reg_rd    = 1'b0;
  reg         rd_d      = 1'b0;
  reg  [31:0] sd        = 32'h19624D6B;
  reg  [7:0]  d0, d1, d2, b;
  wire [7:0]  reg_rdata, data_in, data_out, data_oe;
  wire        rd_n, wr_n, cs_n, irq;
  integer     err_count   = 0;
  integer     comparisons = 0;
  logic [7:0] exp_q[$];
  initial forever #4 clk = ~clk;
  slave_byte_port slave_byte_port_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .read_strobe_pin_n(rd_n),
    .write_strobe_pin_n(wr_n), .chip_select_pin_n(cs_n), .irq(irq));
  ext_master_model ext_master_model_i (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .dq(data_in), .pin_out(data_out), .pin_oe(data_oe));
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task getr(output [7:0] v);
  begin
    sd = lfsr(sd);
    v = sd[7:0];
  end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
  begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  end
  endtask
  // read data stand only in the cycle after the strobe, so compare exactly there
  always @(posedge clk)
  begin
    if (rd_d)
      chk(reg_rdata, exp_q.pop_front());
    rd_d <= reg_rd;
  end
  task wr(input [7:0] a, input [7:0] d);
  begin
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge clk);
  end
  endtask
  task rd(input [7:0] a, input [7:0] e);
  begin
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    exp_q.push_back(e);
    @(posedge clk);
  end
  endtask
  task idle(input integer n);
  begin
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge clk);
  end
  endtask
  task close_out;
  begin
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  initial
  begin
    #400000;
    err_count = err_count + 1;
    close_out;
  end
  initial
  begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'h89, 8'h07);
    rd(8'h0C, 8'h00);
    rd(8'h8C, 8'h00);
    rd(8'h9F, 8'h00);
    rd(8'h55, 8'h00);
    getr(d0);
    wr(8'h09, d0);
    rd(8'h09, d0 & 8'h07);
    wr(8'h9F, 8'h06);
    wr(8'h89, 8'h17);
    wr(8'h8C, 8'h80);
    wr(8'h08, d0);
    rd(8'h89, 8'h57);
    idle(1);
    ext_master_model_i.mread(b);
    chk(b, d0);
    rd(8'h89, 8'h17);
    idle(2);
    chk({7'h00, irq}, 8'h01);
    wr(8'hA0, 8'h80);
    idle(3);
    chk({7'h00, irq}, 8'h00);
    getr(d1);
    getr(d2);
    ext_master_model_i.mwrite(d1);
    rd(8'h89, 8'h97);
    rd(8'h0C, 8'h80);
    idle(1);
    ext_master_model_i.mwrite(d2);
    rd(8'h89, 8'hB7);
    rd(8'h08, d2);
    rd(8'h89, 8'h37);
    wr(8'h8C, 8'h00);
    idle(3);
    chk({7'h00, irq}, 8'h00);
    wr(8'h8C, 8'h80);
    idle(3);
    chk({7'h00, irq}, 8'h01);
    wr(8'h08, d1);
    wr(8'h89, 8'h27);
    rd(8'h89, 8'h27);
    wr(8'h89, 8'h07);
    rd(8'h89, 8'h07);
    idle(2);
    close_out;
  end
endmodule
